// File: inc/period_timer_pkg.sv
// Operation
// - count advances by one from zero on each prescaled instruction-clock tick
// - count compared with period on each prescaled tick; equality there gives match pulse
// - after match count reloads zero next cycle and postscaler advances
// - postscale select code n gives ratio 1:(n+1), 1:1 to 1:16
// - interrupt flag is raised by the postscaled match event
// - timer runs while timer_on is 1, stops while 0
// - software reads and writes count and period registers at any time
// - reset clears count and sets period to all ones
// - count write, control write and reset clear prescaler and postscaler
// - control write leaves the count value unchanged
// - control bit 7 ignores writes and reads zero
// - match pulse offered to the sync serial port as shift clock
package period_timer_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] addr_count = 8'h00;
	localparam logic [7:0] addr_period = 8'h04;
	localparam logic [7:0] addr_control = 8'h08;
	localparam logic [7:0] addr_status = 8'h0c;

	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int ctl_on_bit = 2;
	localparam int ctl_post_lsb = 3;
	localparam logic [7:0] count_reset = 8'h00;
	localparam logic [7:0] period_reset = 8'hff;
	localparam logic [6:0] control_reset = 7'h00;
	localparam logic [1:0] instr_div_last = 2'h3;
	localparam logic [3:0] pre_last_div4 = 4'h3;
	localparam logic [3:0] pre_last_div16 = 4'hf;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	typedef struct packed {
		logic [3:0] post_sel;
		logic timer_on;
		logic [1:0] pre_sel;
	} control_t;

	typedef struct packed {
		logic [7:0] count;
		logic [7:0] period;
		logic [3:0] pre_cnt;
		logic [3:0] post_cnt;
		logic [1:0] instr_div;
		logic flag;
	} timer_state_t;

endpackage

// File: hdl/period_match_timer.sv
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module period_match_timer
	import period_timer_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic match_pulse,
	output logic serial_shift_clk,
	output logic timer_flag
);

	// ------------------------------------------------------------
	// write channel: address and data latched in either order
	// ------------------------------------------------------------
	logic aw_held_r, aw_held_nxt;
	logic w_held_r, w_held_nxt;
	logic [7:0] aw_addr_r, aw_addr_nxt;
	logic [31:0] w_data_r, w_data_nxt;
	logic [3:0] w_strb_r, w_strb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic wr_fire;
	logic wr_lane0;
	logic wr_count, wr_period, wr_control, wr_status, wr_known;

	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	always_comb begin
		aw_held_nxt = aw_held_r;
		w_held_nxt = w_held_r;
		aw_addr_nxt = aw_addr_r;
		w_data_nxt = w_data_r;
		w_strb_nxt = w_strb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_nxt = 1'b1;
			w_data_nxt = s_axi_wdata;
			w_strb_nxt = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = wr_known ? resp_okay : resp_slverr;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
	end

	// a write takes effect one cycle after both halves are held
	assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
	assign wr_lane0 = wr_fire && w_strb_r[0];

	always_comb begin
		wr_count = 1'b0;
		wr_period = 1'b0;
		wr_control = 1'b0;
		wr_status = 1'b0;
		if (aw_addr_r == addr_count) begin
			wr_count = 1'b1;
		end else if (aw_addr_r == addr_period) begin
			wr_period = 1'b1;
		end else if (aw_addr_r == addr_control) begin
			wr_control = 1'b1;
		end else if (aw_addr_r == addr_status) begin
			wr_status = 1'b1;
		end
	end
	assign wr_known = wr_count || wr_period || wr_control || wr_status;

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	control_t ctl_r, ctl_nxt;

	always_comb begin
		ctl_nxt = ctl_r;
		if (wr_lane0 && wr_control) begin
			ctl_nxt = control_t'(w_data_r[6:0]);
		end
	end

	// ------------------------------------------------------------
	// timer core
	// ------------------------------------------------------------
	timer_state_t st_r, st_nxt;
	logic instr_tick;
	logic pre_tick;
	logic [3:0] pre_last;
	logic is_match;
	logic match_r, match_nxt;
	logic clear_scalers;

	// instruction clock is aclk divided by four
	assign instr_tick = (st_r.instr_div == instr_div_last);

	always_comb begin
		if (ctl_r.pre_sel[1]) begin
			pre_last = pre_last_div16;
		end else if (ctl_r.pre_sel[0]) begin
			pre_last = pre_last_div4;
		end else begin
			pre_last = 4'h0;
		end
	end

	assign pre_tick = instr_tick && ctl_r.timer_on && (st_r.pre_cnt == pre_last);
	assign is_match = (st_r.count == st_r.period);
	assign clear_scalers = wr_lane0 && (wr_count || wr_control);

	always_comb begin
		st_nxt = st_r;
		match_nxt = 1'b0;
		st_nxt.instr_div = st_r.instr_div + 2'h1;
		if (instr_tick && ctl_r.timer_on) begin
			st_nxt.pre_cnt = (st_r.pre_cnt == pre_last) ? 4'h0 : st_r.pre_cnt + 4'h1;
		end
		if (pre_tick) begin
			if (is_match) begin
				// one match per tick, so the pulse stays one cycle wide
				match_nxt = 1'b1;
				st_nxt.count = count_reset;
				if (st_r.post_cnt == ctl_r.post_sel) begin
					st_nxt.post_cnt = 4'h0;
					st_nxt.flag = 1'b1;
				end else begin
					st_nxt.post_cnt = st_r.post_cnt + 4'h1;
				end
			end else begin
				st_nxt.count = st_r.count + 8'h01;
			end
		end
		// software clear of the flag loses to a same-cycle set
		if (wr_lane0 && wr_status && w_data_r[0] && !st_nxt.flag) begin
			st_nxt.flag = 1'b0;
		end else if (wr_lane0 && wr_status && w_data_r[0] && st_r.flag
			&& !(pre_tick && is_match && st_r.post_cnt == ctl_r.post_sel)) begin
			st_nxt.flag = 1'b0;
		end
		if (clear_scalers) begin
			st_nxt.pre_cnt = 4'h0;
			st_nxt.post_cnt = 4'h0;
		end
		if (wr_lane0 && wr_count) begin
			st_nxt.count = w_data_r[7:0];
		end
		if (wr_lane0 && wr_period) begin
			st_nxt.period = w_data_r[7:0];
		end
		// control write keeps count as is
		if (wr_lane0 && wr_control) begin
			st_nxt.count = st_nxt.count;
		end
	end

	assign match_pulse = match_r;
	assign serial_shift_clk = match_r;
	assign timer_flag = st_r.flag;

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;

	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = resp_okay;
			if (s_axi_araddr == addr_count) begin
				rdata_nxt = {24'h000000, st_r.count};
			end else if (s_axi_araddr == addr_period) begin
				rdata_nxt = {24'h000000, st_r.period};
			end else if (s_axi_araddr == addr_control) begin
				rdata_nxt = {24'h000000, 1'b0, ctl_r};
			end else if (s_axi_araddr == addr_status) begin
				rdata_nxt = {16'h0000, st_r.post_cnt, st_r.pre_cnt, 7'h00, st_r.flag};
			end else begin
				rdata_nxt = 32'h00000000;
				rresp_nxt = resp_slverr;
			end
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= resp_okay;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= resp_okay;
			ctl_r <= control_t'(control_reset);
			st_r.count <= count_reset;
			st_r.period <= period_reset;
			st_r.pre_cnt <= 4'h0;
			st_r.post_cnt <= 4'h0;
			st_r.instr_div <= 2'h0;
			st_r.flag <= 1'b0;
			match_r <= 1'b0;
		end else begin
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			ctl_r <= ctl_nxt;
			st_r <= st_nxt;
			match_r <= match_nxt;
		end
	end

endmodule

// File: test/period_match_timer_chk.sv
`timescale 1ns/1ps
module period_match_timer_chk
	import period_timer_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic match_pulse,
	input wire logic serial_shift_clk,
	input wire logic timer_flag
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	shift_clk_a: assert property (serial_shift_clk == match_pulse)
		else $error("shift clock differs from match");
	match_gap_a: assert property (match_pulse |=> !match_pulse [*3])
		else $error("match pulses closer than one tick");
	flag_cause_a: assert property ($rose(timer_flag) |-> match_pulse || $past(match_pulse))
		else $error("flag rose without match");
	flag_clear_a: assert property ($fell(timer_flag) |-> $rose(s_axi_bvalid))
		else $error("flag fell without a write");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:3] s_axi_bvalid)
		else $error("write response late");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
endmodule

bind period_match_timer period_match_timer_chk period_match_timer_chk_inst (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .match_pulse(match_pulse),
	.serial_shift_clk(serial_shift_clk), .timer_flag(timer_flag));

// File: test/test_period_match_timer.sv
`timescale 1ns/1ps
module test_period_match_timer import period_timer_pkg::*;;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic match_pulse, serial_shift_clk, timer_flag;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_b;
	logic [3:0] s_axi_wstrb;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	int n_fail, cmp_count, n, i;
	period_match_timer period_match_timer_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .match_pulse, .serial_shift_clk, .timer_flag);
	// --------
	// bus tasks
	// --------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		$display("mismatches %0d of %0d compares", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task hang;
		n_fail++;
		tally_and_finish;
	endtask
	// ready is sampled mid-cycle so the handshake edge is never raced
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic ta, tw, tb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		tb = 1'b0;
		for (int k = 0; !tb; k++) begin
			if (k > 50) hang;
			@(negedge aclk);
			ta = (s_axi_awvalid && s_axi_awready) === 1'b1;
			tw = (s_axi_wvalid && s_axi_wready) === 1'b1;
			tb = s_axi_bvalid === 1'b1;
			wr_b = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
		end
	endtask
	task rd(input logic [7:0] a);
		logic ta, tr;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		tr = 1'b0;
		for (int k = 0; !tr; k++) begin
			if (k > 50) hang;
			@(negedge aclk);
			ta = (s_axi_arvalid && s_axi_arready) === 1'b1;
			tr = s_axi_rvalid === 1'b1;
			rd_v = s_axi_rdata;
			rd_r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) s_axi_rready <= 1'b0;
		end
	endtask
	task gap;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
			if (n > 1000) hang;
		end while (match_pulse !== 1'b1);
	endtask
	// --------
	// scenarios
	// --------
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
		s_axi_wstrb = 4'h1;
		n_fail = 0;
		cmp_count = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(addr_count); chk(rd_v, 32'h0);
		rd(addr_period); chk(rd_v, 32'hff);
		wr(addr_control, 8'hfb); rd(addr_control); chk(rd_v, 32'h7b);
		wr(addr_count, 8'h5a);
		wr(addr_control, 8'h03);
		repeat (100) @(posedge aclk);
		rd(addr_count); chk(rd_v, 32'h5a);
		rd(8'h10); chk({30'h0, rd_r}, {30'h0, resp_slverr});
		wr(8'h10, 8'h00); chk({30'h0, wr_b}, {30'h0, resp_slverr});
		wr(addr_period, 8'hff); chk({30'h0, wr_b}, {30'h0, resp_okay});
		wr(addr_count, 8'h00);
		wr(addr_period, 8'h02);
		// period 2 gives three ticks per match
		for (int p = 0; p < 4; p++) begin
			wr(addr_control, {1'b0, 5'h01, p[1:0]});
			gap;
			gap;
			chk(n, 12 * ((p == 0) ? 1 : (p == 1) ? 4 : 16));
		end
		wr(addr_control, 8'h00);
		wr(addr_count, 8'h00);
		wr(addr_period, 8'h00);
		for (int s = 0; s < 16; s++) begin
			wr(addr_control, {1'b0, s[3:0], 3'h0});
			wr(addr_status, 8'h01);
			wr(addr_control, {1'b0, s[3:0], 3'h4});
			n = 0;
			for (i = 0; timer_flag !== 1'b1; i++) begin
				@(negedge aclk);
				if (match_pulse === 1'b1) n++;
				if (i > 1000) hang;
			end
			chk(n, s + 1);
		end
		wr(addr_control, 8'h00);
		wr(addr_status, 8'h01);
		rd(addr_status); chk(rd_v & 32'hff01, 32'h0);
		tally_and_finish;
	end
endmodule
